// ---- logic/exec_unit.sv ----
// execution unit for decrement, divide, loop, irq gate and threaded code
// assumes: operands and program words are supplied ready; one result per instruction
`timescale 1ns/100ps
module exec_unit
  import exec_pkg::*;
(
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  // instruction issue
  input wire logic issue,
  input wire logic [7:0] opcode,
  input wire logic [15:0] dst_val,
  input wire logic [7:0] src_val,
  input wire logic [7:0] rel_ofs,
  input wire logic [15:0] pc_next,
  input wire logic [15:0] prog_word,
  input wire logic [15:0] stack_word,
  input wire logic [7:0] flags_in,
  input wire logic [15:0] sp_in,
  input wire logic [15:0] tp_in,
  // interrupt requests
  input wire logic [7:0] irq_req,
  input wire logic irq_ack,
  // results
  output logic busy,
  output logic done,
  output logic [15:0] res_val,
  output logic res_we,
  output logic res_word,
  output logic [7:0] flags_out,
  output logic [15:0] pc_out,
  output logic pc_we,
  output logic [15:0] sp_out,
  output logic [15:0] tp_out,
  output logic ptr_we,
  output logic push_we,
  output logic [15:0] push_val,
  output logic [7:0] system_mode_reg,
  output logic [7:0] pend_out,
  output logic irq_take
);
  logic rs1_ff, rs2_ff;
  logic rst_n;
  logic [7:0] req1_ff, req2_ff;
  logic [4:0] cyc_ff;
  logic busy_ff;
  logic wait_div_ff;
  logic [7:0] op_ff;
  logic [7:0] fl_ff;
  logic [7:0] mode_ff;
  logic [7:0] pend_ff;
  logic done_ff, res_we_ff, res_word_ff, pc_we_ff, ptr_we_ff, push_we_ff;
  logic [15:0] res_ff, pc_ff, sp_ff, tp_ff, push_ff;
  logic [7:0] dec_b;
  logic [15:0] dec_w;
  logic is_div;
  div_if dv ();

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rs1_ff <= 1'b0;
      rs2_ff <= 1'b0;
    end else begin
      rs1_ff <= 1'b1;
      rs2_ff <= rs1_ff;
    end
  end
  assign rst_n = rs2_ff;

  // arithmetic helpers
  assign dec_b = dst_val[7:0] - 8'h01;
  assign dec_w = dst_val - PTR_ONE;
  assign is_div = (opcode == OP_DIV_R) || (opcode == OP_DIV_IR) || (opcode == OP_DIV_IM);

  // divider request
  assign dv.start = ce && issue && !busy_ff && is_div;
  assign dv.dividend = dst_val;
  assign dv.divisor = src_val;

  udiv16 u_div (
    .clk(sys_clk),
    .rst_n(rst_n),
    .ce(ce),
    .dv(dv)
  );

  // irq request pins synchronised
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      req1_ff <= 8'h00;
      req2_ff <= 8'h00;
    end else if (ce) begin
      req1_ff <= irq_req;
      req2_ff <= req1_ff;
    end
  end

  // pending bits latch regardless of global enable; set beats ack
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_ff <= 8'h00;
    end else if (ce) begin
      pend_ff <= (pend_ff & ~({8{irq_ack && mode_ff[0]}} & pend_ff)) | req2_ff;
    end
  end

  // global enable bit of the mode register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= MODE_RST;
    end else if (ce && issue && !busy_ff) begin
      if (opcode == OP_IRQ_OFF) begin
        mode_ff[0] <= 1'b0;
      end else if (opcode == OP_IRQ_ON) begin
        mode_ff[0] <= 1'b1;
      end
    end
  end

  // execution and cycle count
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      wait_div_ff <= 1'b0;
      cyc_ff <= 5'h00;
      op_ff <= 8'h00;
      fl_ff <= 8'h00;
      res_ff <= PTR_RST;
      pc_ff <= PTR_RST;
      sp_ff <= PTR_RST;
      tp_ff <= PTR_RST;
      push_ff <= PTR_RST;
      done_ff <= 1'b0;
      res_we_ff <= 1'b0;
      res_word_ff <= 1'b0;
      pc_we_ff <= 1'b0;
      ptr_we_ff <= 1'b0;
      push_we_ff <= 1'b0;
    end else if (ce) begin
      done_ff <= 1'b0;
      res_we_ff <= 1'b0;
      pc_we_ff <= 1'b0;
      ptr_we_ff <= 1'b0;
      push_we_ff <= 1'b0;
      if (issue && !busy_ff) begin
        busy_ff <= 1'b1;
        op_ff <= opcode;
        fl_ff <= flags_in;
        cyc_ff <= CYC_IRQ - CYC_MIN;
        res_word_ff <= 1'b0;
        if (opcode == OP_DEC_R || opcode == OP_DEC_IR) begin
          res_ff <= {8'h00, dec_b};
          fl_ff[FL_Z] <= (dec_b == 8'h00);
          fl_ff[FL_S] <= dec_b[7];
          fl_ff[FL_V] <= (dst_val[7:0] == 8'h80);
          res_we_ff <= 1'b0;
          cyc_ff <= CYC_DEC - CYC_MIN;
        end else if (opcode == OP_WORD_MINUS_ONE_OP_RR || opcode == OP_WORD_MINUS_ONE_OP_IR) begin
          res_ff <= dec_w;
          res_word_ff <= 1'b1;
          fl_ff[FL_Z] <= (dec_w == 16'h0000);
          fl_ff[FL_S] <= dec_w[15];
          fl_ff[FL_V] <= (dst_val == 16'h8000);
          cyc_ff <= CYC_WORD - CYC_MIN;
        end else if (is_div) begin
          res_word_ff <= 1'b1;
          if (src_val == 8'h00) begin
            // zero divisor ends before the divider answers, so flags settle here
            wait_div_ff <= 1'b0;
            fl_ff[FL_V] <= 1'b1;
            fl_ff[FL_C] <= 1'b0;
            fl_ff[FL_Z] <= 1'b1;
            fl_ff[FL_S] <= 1'b0;
            cyc_ff <= CYC_DIV0 - CYC_MIN;
          end else begin
            wait_div_ff <= 1'b1;
            cyc_ff <= CYC_DIV - CYC_MIN;
          end
        end else if (opcode[3:0] == OP_LOOP_LO) begin
          res_ff <= {8'h00, dec_b};
          pc_ff <= pc_next + {{8{rel_ofs[7]}}, rel_ofs};
          cyc_ff <= CYC_LOOP - CYC_MIN;
        end else if (opcode == OP_THREAD_CALL) begin
          sp_ff <= sp_in - PTR_STEP;
          push_ff <= tp_in;
          pc_ff <= prog_word;
          tp_ff <= pc_next + PTR_STEP;
          cyc_ff <= CYC_THREAD - CYC_MIN;
        end else if (opcode == OP_THREAD_RET) begin
          sp_ff <= sp_in + PTR_STEP;
          pc_ff <= prog_word;
          tp_ff <= stack_word + PTR_STEP;
          cyc_ff <= CYC_THREAD - CYC_MIN;
        end
      end else if (busy_ff) begin
        if (wait_div_ff && dv.done) begin
          wait_div_ff <= 1'b0;
          res_ff <= {dv.rem, dv.quot};
          fl_ff[FL_V] <= dv.ovf;
          fl_ff[FL_C] <= dv.ovf && dv.carry;
          fl_ff[FL_Z] <= dv.zero;
          fl_ff[FL_S] <= dv.sign;
        end
        if (cyc_ff > CYC_MIN) begin
          cyc_ff <= cyc_ff - CYC_MIN;
        end else begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
          res_we_ff <= (op_ff == OP_DEC_R) || (op_ff == OP_DEC_IR) ||
                       (op_ff == OP_WORD_MINUS_ONE_OP_RR) || (op_ff == OP_WORD_MINUS_ONE_OP_IR) ||
                       (op_ff == OP_DIV_R) || (op_ff == OP_DIV_IR) ||
                       (op_ff == OP_DIV_IM) || (op_ff[3:0] == OP_LOOP_LO);
          pc_we_ff <= ((op_ff[3:0] == OP_LOOP_LO) && (res_ff[7:0] != 8'h00)) ||
                      (op_ff == OP_THREAD_CALL) || (op_ff == OP_THREAD_RET);
          ptr_we_ff <= (op_ff == OP_THREAD_CALL) || (op_ff == OP_THREAD_RET);
          push_we_ff <= (op_ff == OP_THREAD_CALL);
        end
      end
    end
  end

  // outputs
  assign busy = busy_ff;
  assign done = done_ff;
  assign res_val = res_ff;
  assign res_we = res_we_ff;
  assign res_word = res_word_ff;
  assign flags_out = fl_ff;
  assign pc_out = pc_ff;
  assign pc_we = pc_we_ff;
  assign sp_out = sp_ff;
  assign tp_out = tp_ff;
  assign ptr_we = ptr_we_ff;
  assign push_we = push_we_ff;
  assign push_val = push_ff;
  assign system_mode_reg = mode_ff;
  assign pend_out = pend_ff;
  assign irq_take = mode_ff[0] && (pend_ff != 8'h00);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_irq_off;
    @(posedge sys_clk) disable iff (!rst_n)
      (ce && issue && !busy_ff && opcode == OP_IRQ_OFF) |=> !system_mode_reg[0];
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("disable did not clear bit");

  property p_irq_on;
    @(posedge sys_clk) disable iff (!rst_n)
      (ce && issue && !busy_ff && opcode == OP_IRQ_ON) |=> system_mode_reg[0];
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("enable did not set bit");

  property p_no_take;
    @(posedge sys_clk) disable iff (!rst_n) !system_mode_reg[0] |-> !irq_take;
  endproperty
  a_no_take: assert property (p_no_take) else $error("irq taken while disabled");

  property p_take;
    @(posedge sys_clk) disable iff (!rst_n)
      (system_mode_reg[0] && pend_out != 8'h00) |-> irq_take;
  endproperty
  a_take: assert property (p_take) else $error("pending irq not taken");

  sequence s_div0;
    ce && issue && !busy_ff && is_div && src_val == 8'h00;
  endsequence
  property p_div0_len;
    @(posedge sys_clk) disable iff (!rst_n) s_div0 |-> ##10 done;
  endproperty
  a_div0_len: assert property (p_div0_len) else $error("zero divide not 10 cycles");

  property p_div0_flags;
    @(posedge sys_clk) disable iff (!rst_n)
      s_div0 |-> ##10 (flags_out[FL_V] && flags_out[FL_Z]);
  endproperty
  a_div0_flags: assert property (p_div0_flags) else $error("zero divide flags");

  property p_div_len;
    @(posedge sys_clk) disable iff (!rst_n)
      (ce && issue && !busy_ff && is_div && src_val != 8'h00) |-> ##26 done;
  endproperty
  a_div_len: assert property (p_div_len) else $error("divide not 26 cycles");

  property p_carry;
    @(posedge sys_clk) disable iff (!rst_n)
      (done && flags_out[FL_C] && (op_ff == OP_DIV_R || op_ff == OP_DIV_IR || op_ff == OP_DIV_IM))
      |-> flags_out[FL_V];
  endproperty
  a_carry: assert property (p_carry) else $error("carry without overflow");

  sequence s_irq_take;
    ce && issue && !busy_ff && (opcode == OP_IRQ_OFF || opcode == OP_IRQ_ON);
  endsequence
  property p_irq_len;
    @(posedge sys_clk) disable iff (!rst_n) s_irq_take ##1 ce[*3] |=> done;
  endproperty
  a_irq_len: assert property (p_irq_len) else $error("irq op not 4 cycles");

  sequence s_keep_take;
    ce && issue && !busy_ff && (opcode == OP_IRQ_OFF || opcode == OP_IRQ_ON ||
      opcode[3:0] == OP_LOOP_LO || opcode == OP_THREAD_CALL || opcode == OP_THREAD_RET);
  endsequence
  property p_keep_flags;
    @(posedge sys_clk) disable iff (!rst_n) s_keep_take |=> (flags_out == $past(flags_in));
  endproperty
  a_keep_flags: assert property (p_keep_flags) else $error("flags changed by flagless op");

  property p_strobe_done;
    @(posedge sys_clk) disable iff (!rst_n) (res_we || pc_we || ptr_we || push_we) |-> done;
  endproperty
  a_strobe_done: assert property (p_strobe_done) else $error("write strobe without done");

  property p_loop_pc;
    @(posedge sys_clk) disable iff (!rst_n)
      (done && op_ff[3:0] == OP_LOOP_LO) |-> (pc_we == (res_val[7:0] != 8'h00));
  endproperty
  a_loop_pc: assert property (p_loop_pc) else $error("loop branch strobe wrong");
endmodule // exec_unit

// ---- shared/exec_pkg.sv ----
// package: opcodes, flag positions and cycle counts for the execution unit
// assumes: the fetch logic hands over whole instructions with operands fetched
package exec_pkg;
  // opcodes
  localparam logic [7:0] OP_DEC_R = 8'h00;
  localparam logic [7:0] OP_DEC_IR = 8'h01;
  localparam logic [7:0] OP_WORD_MINUS_ONE_OP_RR = 8'h80;
  localparam logic [7:0] OP_WORD_MINUS_ONE_OP_IR = 8'h81;
  localparam logic [7:0] OP_IRQ_OFF = 8'h8f;
  localparam logic [7:0] OP_IRQ_ON = 8'h9f;
  localparam logic [7:0] OP_DIV_R = 8'h94;
  localparam logic [7:0] OP_DIV_IR = 8'h95;
  localparam logic [7:0] OP_DIV_IM = 8'h96;
  localparam logic [3:0] OP_LOOP_LO = 4'ha;
  localparam logic [7:0] OP_THREAD_CALL = 8'h1f;
  localparam logic [7:0] OP_THREAD_RET = 8'h2f;
  // flag bit positions
  localparam int FL_C = 7;
  localparam int FL_Z = 6;
  localparam int FL_S = 5;
  localparam int FL_V = 4;
  // cycle counts
  localparam logic [4:0] CYC_DEC = 5'h04;
  localparam logic [4:0] CYC_WORD = 5'h08;
  localparam logic [4:0] CYC_IRQ = 5'h04;
  localparam logic [4:0] CYC_DIV = 5'h1a;
  localparam logic [4:0] CYC_DIV0 = 5'h0a;
  localparam logic [4:0] CYC_LOOP = 5'h08;
  localparam logic [4:0] CYC_THREAD = 5'h08;
  localparam logic [4:0] CYC_MIN = 5'h01;
  // reset values and step constants
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [15:0] PTR_STEP = 16'h0002;
  localparam logic [15:0] PTR_ONE = 16'h0001;
endpackage

// ---- shared/div_if.sv ----
// interface: request and answer between the executor and the divider
// assumes: one clock, both ends on sys_clk
`timescale 1ns/100ps
interface div_if;
  logic start;
  logic [15:0] dividend;
  logic [7:0] divisor;
  logic done;
  logic [7:0] quot;
  logic [7:0] rem;
  logic ovf;
  logic carry;
  logic zero;
  logic sign;
  modport req (output start, output dividend, output divisor,
    input done, input quot, input rem, input ovf, input carry, input zero, input sign);
  modport rsp (input start, input dividend, input divisor,
    output done, output quot, output rem, output ovf, output carry, output zero, output sign);
endinterface

// ---- logic/udiv16.sv ----
// unsigned 16 by 8 restoring divider with registered results
// assumes: synchronous reset copy and clock enable from the executor
`timescale 1ns/100ps
module udiv16
  import exec_pkg::*;
(
  // clock and control
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // request and answer
  div_if.rsp dv
);
  logic [16:0] rem_ff;
  logic [15:0] quo_ff;
  logic [7:0] dsr_ff;
  logic [4:0] cnt_ff;
  logic busy_ff;
  logic done_ff;
  logic [16:0] trial;

  // one quotient bit per cycle, sixteen steps
  assign trial = {rem_ff[15:0], quo_ff[15]} - {9'h000, dsr_ff};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_ff <= 17'h00000;
      quo_ff <= 16'h0000;
      dsr_ff <= 8'h00;
      cnt_ff <= 5'h00;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (ce) begin
      done_ff <= 1'b0;
      if (dv.start) begin
        rem_ff <= 17'h00000;
        quo_ff <= dv.dividend;
        dsr_ff <= dv.divisor;
        cnt_ff <= 5'h10;
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        if (trial[16]) begin
          rem_ff <= {rem_ff[15:0], quo_ff[15]};
          quo_ff <= {quo_ff[14:0], 1'b0};
        end else begin
          rem_ff <= trial;
          quo_ff <= {quo_ff[14:0], 1'b1};
        end
        cnt_ff <= cnt_ff - 5'h01;
        if (cnt_ff == 5'h01) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end
      end
    end
  end

  // result fields and flags, valid while done is high
  assign dv.done = done_ff;
  assign dv.quot = quo_ff[7:0];
  assign dv.rem = rem_ff[7:0];
  assign dv.ovf = (quo_ff[15:8] != 8'h00) || (dsr_ff == 8'h00);
  assign dv.carry = (quo_ff[15:9] == 7'h00) && quo_ff[8];
  assign dv.zero = (dsr_ff == 8'h00) || (quo_ff == 16'h0000);
  assign dv.sign = quo_ff[7];
endmodule // udiv16

// ---- sim/cpu_dec_div_loop_irq_exec_tb_top.sv ----
// testbench: drives the execution unit, notes expected results in a queue, checks at done
// assumes: exec_pkg, div_if and the design files are compiled first
`timescale 1ns/100ps
module cpu_dec_div_loop_irq_exec_tb_top;
  import exec_pkg::*;
  // ------------------------------------------------------------
  // signals and expectation notes
  // ------------------------------------------------------------
  typedef struct {
    logic [15:0] res, res_m, pc, sp, tp, pv;
    logic [7:0] fl, fl_m;
    logic pcw, thr, psh, we, wrd;
    int cyc, take;
  } note_t;
  note_t notes[$];
  note_t m;
  logic sys_clk = 1'b0, rstn = 1'b0, ce = 1'b1, issue = 1'b0, irq_ack = 1'b0;
  logic [7:0] opcode = 8'h00, src_val = 8'h00, rel_ofs = 8'h00, flags_in = 8'h00;
  logic [7:0] irq_req = 8'h00;
  logic [15:0] dst_val = 16'h0000, pc_next = 16'h0000, prog_word = 16'h0000;
  logic [15:0] stack_word = 16'h0000, sp_in = 16'h0000, tp_in = 16'h0000;
  logic busy, done, res_we, res_word, pc_we, ptr_we, push_we, irq_take;
  logic [15:0] res_val, pc_out, sp_out, tp_out, push_val;
  logic [7:0] flags_out, system_mode_reg, pend_out;
  logic [31:0] seed = 32'h3d50;
  int n_errors = 0, total_checks = 0, cyc_cnt = 0, i;
  logic [15:0] bd [4] = '{16'h0000, 16'h0001, 16'h0080, 16'h007f};
  logic [15:0] wd [4] = '{16'h0000, 16'h0001, 16'h8000, 16'h1234};
  logic [23:0] dv [8] = '{24'h100340, 24'h100300, 24'h010001, 24'hffff01,
                          24'h000510, 24'h008001, 24'h01ff01, 24'h020001};

  // 200 MHz clock and a cycle count for latency checks
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc_cnt <= cyc_cnt + 1;

  exec_unit dut_u (.sys_clk(sys_clk), .rstn(rstn), .ce(ce), .issue(issue), .opcode(opcode),
    .dst_val(dst_val), .src_val(src_val), .rel_ofs(rel_ofs), .pc_next(pc_next),
    .prog_word(prog_word), .stack_word(stack_word), .flags_in(flags_in), .sp_in(sp_in),
    .tp_in(tp_in), .irq_req(irq_req), .irq_ack(irq_ack), .busy(busy), .done(done),
    .res_val(res_val), .res_we(res_we), .res_word(res_word), .flags_out(flags_out),
    .pc_out(pc_out), .pc_we(pc_we), .sp_out(sp_out), .tp_out(tp_out), .ptr_we(ptr_we),
    .push_we(push_we), .push_val(push_val), .system_mode_reg(system_mode_reg),
    .pend_out(pend_out), .irq_take(irq_take));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0] ^ seed[31:16];
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic conclude();
    $display("checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // issue one instruction, note its expected outcome, wait for it to finish
  // stall > 0 drops ce for that many edges; stall < 0 tries an issue while busy
  task automatic exec(input logic [7:0] op, input logic [15:0] dst, input logic [7:0] src,
                      input logic [7:0] ofs, input int stall);
    note_t n;
    logic [16:0] q;
    logic [15:0] w, pcn, pw, sw, sp, tp;
    logic v;
    logic [7:0] fi;
    int k;
    n = '{default: '0};
    fi = 8'(rnd());
    n.fl = fi;
    pcn = rnd(); pw = rnd(); sw = rnd(); sp = rnd(); tp = rnd();
    n.fl_m = 8'hff;
    n.cyc = 4;
    w = dst - 16'h0001;
    if (op == OP_DEC_R || op == OP_DEC_IR) begin
      n.res = {8'h00, w[7:0]};
      n.res_m = 16'h00ff;
      n.we = 1'b1;
      n.fl[6:4] = {w[7:0] == 8'h00, w[7], dst[7:0] == 8'h80};
    end else if (op == OP_WORD_MINUS_ONE_OP_RR || op == OP_WORD_MINUS_ONE_OP_IR) begin
      n.res = w;
      n.res_m = 16'hffff;
      n.fl[6:4] = {w == 16'h0000, w[15], dst == 16'h8000};
      n.we = 1'b1;
      n.wrd = 1'b1;
      n.cyc = 8;
    end else if (op == OP_DIV_R || op == OP_DIV_IR || op == OP_DIV_IM) begin
      q = (src == 8'h00) ? 17'h00000 : {1'b0, dst / {8'h00, src}};
      v = (src == 8'h00) || (q >= 17'h00100);
      n.fl[7:4] = {v && src != 8'h00 && q < 17'h00200, src == 8'h00 || q == 17'h0, q[7], v};
      if (v) n.fl_m = 8'hdf;
      else begin
        n.res = {8'(dst % {8'h00, src}), q[7:0]};
        n.res_m = 16'hffff;
      end
      n.cyc = (src == 8'h00) ? 10 : 26;
      n.we = 1'b1;
      n.wrd = 1'b1;
    end else if (op[3:0] == OP_LOOP_LO) begin
      n.res = {8'h00, w[7:0]};
      n.res_m = 16'h00ff;
      n.pcw = (w[7:0] != 8'h00);
      n.we = 1'b1;
      n.pc = pcn + {{8{ofs[7]}}, ofs};
      n.cyc = 8;
    end else if (op == OP_THREAD_CALL || op == OP_THREAD_RET) begin
      n.thr = 1'b1;
      n.pcw = 1'b1;
      n.pc = pw;
      n.psh = (op == OP_THREAD_CALL);
      n.sp = n.psh ? sp - 16'h0002 : sp + 16'h0002;
      n.tp = n.psh ? pcn + 16'h0002 : sw + 16'h0002;
      n.pv = tp;
      n.cyc = 8;
    end
    @(posedge sys_clk);
    issue <= 1'b1; opcode <= op; dst_val <= dst; src_val <= src; rel_ofs <= ofs;
    pc_next <= pcn; prog_word <= pw; stack_word <= sw; flags_in <= fi;
    sp_in <= sp; tp_in <= tp;
    @(posedge sys_clk);
    issue <= 1'b0;
    ce <= (stall <= 0);
    #1;
    // count from the issue cycle, so an N-cycle op shows done N counts later
    n.take = cyc_cnt - 1;
    if (stall > 0) n.cyc += stall;
    notes.push_back(n);
    if (stall > 0) begin
      repeat (stall) @(posedge sys_clk);
      ce <= 1'b1;
    end else if (stall < 0) begin
      repeat (3) @(posedge sys_clk);
      issue <= 1'b1;
      opcode <= OP_IRQ_ON;
      @(posedge sys_clk);
      issue <= 1'b0;
    end
    k = 0;
    do begin
      @(negedge sys_clk);
      k++;
    end while (busy !== 1'b0 && k < 40);
    if (k >= 40) chk("busy", 16'h0000, 16'h0001);
  endtask

  // ------------------------------------------------------------
  // result monitor: oldest note is compared whenever done pulses
  // ------------------------------------------------------------
  always @(negedge sys_clk) begin
    if (done === 1'b1) begin
      if (notes.size() == 0) chk("spare done", 16'h0000, 16'h0001);
      else begin
        m = notes.pop_front();
        chk("cycles", 16'(m.cyc), 16'(cyc_cnt - m.take));
        chk("result", m.res & m.res_m, res_val & m.res_m);
        chk("flags", {8'h00, m.fl & m.fl_m}, {8'h00, flags_out & m.fl_m});
        chk("pc write", {15'h0, m.pcw}, {15'h0, pc_we});
        chk("result write", {15'h0, m.we}, {15'h0, res_we});
        chk("word result", {15'h0, m.wrd}, {15'h0, res_word});
        chk("pointer write", {15'h0, m.thr}, {15'h0, ptr_we});
        if (m.pcw) chk("pc", m.pc, pc_out);
        if (m.thr) begin
          chk("stack ptr", m.sp, sp_out);
          chk("thread ptr", m.tp, tp_out);
          chk("push", {15'h0, m.psh}, {15'h0, push_we});
          if (m.psh) chk("push value", m.pv, push_val);
        end
      end
    end
  end

  // watchdog
  initial begin
    #100000;
    n_errors++;
    conclude();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("mode after reset", {8'h00, MODE_RST}, {8'h00, system_mode_reg});
    for (i = 0; i < 8; i++) exec(i[0] ? OP_DEC_IR : OP_DEC_R, i < 4 ? bd[i] : rnd(), 0, 0, 0);
    for (i = 0; i < 8; i++) exec(i[0] ? OP_WORD_MINUS_ONE_OP_IR : OP_WORD_MINUS_ONE_OP_RR, i < 4 ? wd[i] : rnd(), 0, 0, 0);
    for (i = 0; i < 12; i++) begin
      if (i < 8) exec(8'(OP_DIV_R + i % 3), dv[i][23:8], dv[i][7:0], 0, 0);
      else exec(8'(OP_DIV_R + i % 3), rnd(), 8'(rnd()), 0, 0);
    end
    exec({4'h1, OP_LOOP_LO}, 16'h0001, 0, 8'h7f, 0);
    exec({4'hc, OP_LOOP_LO}, 16'h0002, 0, 8'h7f, 0);
    exec({4'hf, OP_LOOP_LO}, 16'h0002, 0, 8'h80, 0);
    i = rnd();
    exec({i[3:0], OP_LOOP_LO}, rnd(), 0, 8'(rnd()), 0);
    for (i = 0; i < 4; i++) exec(i[0] ? OP_THREAD_RET : OP_THREAD_CALL, 0, 0, 0, 0);
    // requests pend while disabled, then get served once enabled
    irq_req <= 8'h08;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("pending", 16'h0001, {15'h0, pend_out[3]});
    chk("take off", 16'h0000, {15'h0, irq_take});
    exec(OP_IRQ_ON, 0, 0, 0, 0);
    chk("mode on", 16'h0001, {15'h0, system_mode_reg[0]});
    chk("take on", 16'h0001, {15'h0, irq_take});
    @(posedge sys_clk);
    irq_req <= 8'h00;
    // let the dropped request drain through the synchroniser before acknowledging
    repeat (3) @(posedge sys_clk);
    irq_ack <= 1'b1;
    @(posedge sys_clk);
    irq_ack <= 1'b0;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("pending cleared", 16'h0000, {8'h00, pend_out});
    exec(OP_IRQ_OFF, 0, 0, 0, 0);
    chk("mode off", 16'h0000, {15'h0, system_mode_reg[0]});
    irq_req <= 8'h10;
    exec(OP_DIV_R, 16'h1003, 8'h40, 0, -1);
    chk("refused issue", 16'h0000, {15'h0, system_mode_reg[0]});
    chk("take masked", 16'h0000, {15'h0, irq_take});
    exec(OP_WORD_MINUS_ONE_OP_RR, rnd(), 0, 0, 3);
    exec(OP_IRQ_ON, 0, 0, 0, 0);
    chk("late take", 16'h0001, {15'h0, irq_take});
    repeat (4) @(posedge sys_clk);
    chk("notes left", 16'h0000, 16'(notes.size()));
    conclude();
  end
endmodule // cpu_dec_div_loop_irq_exec_tb_top
